// *** rtl/indcv_device.sv ***
// converter end: register file, sleep control and channel sequencer
`timescale 1ns/1ns
module indcv_device
	import indcv_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	indcv_link_if.dev link, // register link
	input wire logic ref_tick_int_i, // internal reference tick
	input wire logic ref_tick_ext_i, // external reference tick
	input wire logic [27:0] sample_i, // converter core result
	output logic [1:0] chan_o, // channel being driven
	output logic converting_o, // conversion window active
	output logic settling_o, // settling window active
	output logic ref_ext_o, // external reference chosen
	output logic auto_cal_o, // drive auto calibration on
	output logic full_init_drive_o, // full drive at activation
	output logic amp_corr_o, // amplitude correction on
	output logic [2:0] deglitch_o, // deglitch bandwidth code
	output logic [4:0] drive_level_o // drive current in use
);
	logic [15:0] ref_count [2];
	logic [15:0] settle [2];
	logic [15:0] fdiv [2];
	logic [15:0] drive [2];
	logic [15:0] err_mask, control, seq;
	logic [27:0] buf_res [2];
	logic [27:0] shown [2];
	logic [15:0] status;
	logic irq;
	indcv_state_t state;
	logic [9:0] div_cnt;
	logic [19:0] tick_cnt;
	logic [3:0] sub_cnt;
	logic [15:0] sw_cnt;
	logic ch;
	logic ref_tick, ch_tick, wr, rd, sleeping, done;
	logic [1:0] ref_s_int, ref_s_ext;

	assign wr = link.req & link.we & ~link.ack;
	assign rd = link.req & ~link.we & ~link.ack;
	assign sleeping = control[B_SLEEP];
	assign ref_tick = control[B_REF_SRC] ? ref_s_ext[1] : ref_s_int[1];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_s_int <= 2'h0;
			ref_s_ext <= 2'h0;
		end else begin
			ref_s_int <= {ref_s_int[0], ref_tick_int_i};
			ref_s_ext <= {ref_s_ext[0], ref_tick_ext_i};
		end
	end

	// setup writes only land while asleep; control is always writable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control <= RST_CONTROL;
			seq <= RST_SEQ;
			err_mask <= RST_ERR;
			for (int i = 0; i < 2; i++) begin
				ref_count[i] <= RST_COUNT;
				settle[i] <= RST_COUNT;
				fdiv[i] <= RST_FDIV;
				drive[i] <= 16'h0000;
			end
		end else if (wr) begin
			if (link.addr == A_CONTROL) begin
				control <= link.wdata;
			end else if (sleeping) begin
				if (link.addr == A_REF_COUNT0) begin
					ref_count[0] <= link.wdata;
				end else if (link.addr == A_REF_COUNT1) begin
					ref_count[1] <= link.wdata;
				end else if (link.addr == A_SETTLE0) begin
					settle[0] <= link.wdata;
				end else if (link.addr == A_SETTLE1) begin
					settle[1] <= link.wdata;
				end else if (link.addr == A_FDIV0) begin
					fdiv[0] <= link.wdata;
				end else if (link.addr == A_FDIV1) begin
					fdiv[1] <= link.wdata;
				end else if (link.addr == A_ERR_MASK) begin
					err_mask <= link.wdata;
				end else if (link.addr == A_SEQ) begin
					seq <= link.wdata;
				end else if (link.addr == A_DRIVE0) begin
					drive[0] <= link.wdata;
				end else if (link.addr == A_DRIVE1) begin
					drive[1] <= link.wdata;
				end
			end
		end
	end

	// per-channel reference divider, one enable pulse per divided period
	always_ff @(posedge clk_i) begin
		if (rst_i || sleeping) begin
			div_cnt <= 10'h000;
		end else if (ref_tick) begin
			if (div_cnt + 10'h001 >= fdiv[ch][B_FREF_HI:B_FREF_LO]) begin
				div_cnt <= 10'h000;
			end else begin
				div_cnt <= div_cnt + 10'h001;
			end
		end
	end
	assign ch_tick = ref_tick && (div_cnt + 10'h001 >= fdiv[ch][B_FREF_HI:B_FREF_LO]);

	assign done = ch_tick && sub_cnt == 4'(TICKS_PER_UNIT - 1)
		&& tick_cnt + 20'h1 >= 20'(state == INDCV_SETTLE ? settle[ch] : ref_count[ch]);

	always_ff @(posedge clk_i) begin
		if (rst_i || sleeping) begin
			state <= INDCV_SLEEP;
			ch <= 1'b0;
			tick_cnt <= 20'h0;
			sub_cnt <= 4'h0;
			sw_cnt <= 16'h0;
		end else begin
			case (state)
				INDCV_SLEEP: begin
					state <= INDCV_SETTLE;
					ch <= seq[B_SCAN] ? 1'b0 : control[B_ACTIVE_LO];
				end
				INDCV_SETTLE, INDCV_CONVERT: begin
					if (ch_tick) begin
						sub_cnt <= sub_cnt + 4'h1;
						if (sub_cnt == 4'(TICKS_PER_UNIT - 1)) begin
							tick_cnt <= tick_cnt + 20'h1;
						end
					end
					if (done) begin
						tick_cnt <= 20'h0;
						sub_cnt <= 4'h0;
						state <= (state == INDCV_SETTLE) ? INDCV_CONVERT : INDCV_SWITCH;
					end
				end
				INDCV_SWITCH: begin
					sw_cnt <= sw_cnt + 16'h1;
					if (sw_cnt + 16'h1 >= 16'(SWITCH_CYC)) begin
						sw_cnt <= 16'h0;
						state <= INDCV_SETTLE;
						if (seq[B_SCAN] && seq[B_RR_HI:B_RR_LO] == 2'h0) begin
							ch <= ~ch;
						end
					end
				end
				default: state <= INDCV_SLEEP;
			endcase
		end
	end

	// result capture, status and interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i || sleeping) begin
			buf_res[0] <= 28'h0;
			buf_res[1] <= 28'h0;
			shown[0] <= 28'h0;
			shown[1] <= 28'h0;
			status <= 16'h0;
			irq <= 1'b0;
		end else begin
			if (state == INDCV_CONVERT && done) begin
				buf_res[ch] <= sample_i;
				if (!seq[B_SCAN] || ch) begin
					status[B_DRDY] <= 1'b1;
					irq <= err_mask[B_DRDY];
				end
			end
			if (rd && link.addr == A_DATA0_MSB) begin
				shown[0] <= buf_res[0];
			end
			if (rd && link.addr == A_DATA1_MSB) begin
				shown[1] <= buf_res[1];
			end
			if (rd && (link.addr == A_STATUS || link.addr == A_DATA0_MSB
				|| link.addr == A_DATA1_MSB) && !(state == INDCV_CONVERT && done)) begin
				irq <= 1'b0;
				status <= 16'h0;
			end
		end
	end

	// link answer: one cycle after request, data registered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.ack <= 1'b0;
			link.rdata <= 16'h0;
		end else begin
			link.ack <= link.req & ~link.ack;
			if (rd) begin
				if (link.addr == A_DATA0_MSB) begin
					link.rdata <= {4'h0, buf_res[0][27:16]};
				end else if (link.addr == A_DATA0_LSB) begin
					link.rdata <= shown[0][15:0];
				end else if (link.addr == A_DATA1_MSB) begin
					link.rdata <= {4'h0, buf_res[1][27:16]};
				end else if (link.addr == A_DATA1_LSB) begin
					link.rdata <= shown[1][15:0];
				end else if (link.addr == A_REF_COUNT0) begin
					link.rdata <= ref_count[0];
				end else if (link.addr == A_REF_COUNT1) begin
					link.rdata <= ref_count[1];
				end else if (link.addr == A_SETTLE0) begin
					link.rdata <= settle[0];
				end else if (link.addr == A_SETTLE1) begin
					link.rdata <= settle[1];
				end else if (link.addr == A_FDIV0) begin
					link.rdata <= fdiv[0];
				end else if (link.addr == A_FDIV1) begin
					link.rdata <= fdiv[1];
				end else if (link.addr == A_STATUS) begin
					link.rdata <= status;
				end else if (link.addr == A_ERR_MASK) begin
					link.rdata <= err_mask;
				end else if (link.addr == A_CONTROL) begin
					link.rdata <= control;
				end else if (link.addr == A_SEQ) begin
					link.rdata <= seq;
				end else if (link.addr == A_DRIVE0) begin
					link.rdata <= drive[0];
				end else if (link.addr == A_DRIVE1) begin
					link.rdata <= drive[1];
				end else begin
					link.rdata <= 16'h0;
				end
			end
		end
	end

	assign link.int_n = ~(irq & ~control[B_INT_DIS]);
	assign chan_o = {1'b0, ch};
	assign converting_o = state == INDCV_CONVERT;
	assign settling_o = state == INDCV_SETTLE;
	assign ref_ext_o = control[B_REF_SRC];
	assign auto_cal_o = ~control[B_RES_OVR];
	assign full_init_drive_o = ~control[B_ACT_SEL];
	assign amp_corr_o = ~control[B_AMP_OFF];
	assign deglitch_o = seq[B_DG_HI:B_DG_LO];
	// programmed level used when override set
	assign drive_level_o = control[B_RES_OVR] ? drive[ch][B_IDRV_HI:B_IDRV_LO] : 5'h00;
endmodule : indcv_device

// *** rtl/indcv_host.sv ***
// host end: wishbone slave that relays register accesses onto the link
`timescale 1ns/1ns
module indcv_host
	import indcv_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	indcv_link_if.host link, // register link
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [31:0] wb_adr_i, // byte address, index*4
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic irq_o // device interrupt, high
);
	indcv_hstate_t st;

	// ordering of setup, control and result reads is software's job
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= INDCV_H_IDLE;
			link.req <= 1'b0;
			link.we <= 1'b0;
			link.addr <= 8'h00;
			link.wdata <= 16'h0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= 1'b0;
			case (st)
				INDCV_H_IDLE: begin
					if (wb_cyc_i && wb_stb_i) begin
						link.req <= 1'b1;
						link.we <= wb_we_i && wb_sel_i[1:0] == 2'h3;
						link.addr <= wb_adr_i[9:2];
						link.wdata <= wb_dat_i[15:0];
						st <= INDCV_H_WAIT;
					end
				end
				INDCV_H_WAIT: begin
					if (link.ack) begin
						link.req <= 1'b0;
						wb_dat_o <= {16'h0, link.rdata};
						wb_ack_o <= 1'b1;
						st <= INDCV_H_DONE;
					end
				end
				default: st <= INDCV_H_IDLE;
			endcase
		end
	end

	// same clock as the device, so one register and no synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= ~link.int_n;
		end
	end
endmodule : indcv_host

// *** rtl/indcv_link_if.sv ***
// register access link between host controller and converter
`timescale 1ns/1ns
interface indcv_link_if;
	import indcv_pkg::*;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	logic int_n;
	modport dev (input req, input we, input addr, input wdata, output ack, output rdata,
		output int_n);
	modport host (output req, output we, output addr, output wdata, input ack, input rdata,
		input int_n);
endinterface : indcv_link_if

// *** rtl/indcv_pkg.sv ***
// constants shared by both ends of the converter setup link
// Notes on behaviour
// - device wakes up asleep, no conversions
// - host writes control register last
// - conversion time is count times sixteen ref periods
// - settle lasts settle count times sixteen periods
// - host keeps divided reference above four times sensor
// - sensor divider one only below 8.75 MHz
// - single channel select b00 converts channel 0
// - clearing sleep field starts conversions
// - resistance override uses programmed drive current
// - activation select b0 gives full startup drive
// - amplitude correction off field stops correction
// - reference select b1 uses external input
// - scan field b1 enables sequential mode
// - round robin b00 alternates channels 0 and 1
// - deglitch b100 selects 3.3 MHz bandwidth
// - default error mask raises no interrupts
// - results of channels 0,1 at 0x00..0x03
// - channel switch delay about 1 us
// - host writes setup registers before control
// - divider fields at [15:12] and [9:0]
// - reading status releases interrupt output high
package indcv_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] A_DATA0_MSB = 8'h00;
	localparam logic [7:0] A_DATA0_LSB = 8'h01;
	localparam logic [7:0] A_DATA1_MSB = 8'h02;
	localparam logic [7:0] A_DATA1_LSB = 8'h03;
	localparam logic [7:0] A_REF_COUNT0 = 8'h08;
	localparam logic [7:0] A_REF_COUNT1 = 8'h09;
	localparam logic [7:0] A_SETTLE0 = 8'h10;
	localparam logic [7:0] A_SETTLE1 = 8'h11;
	localparam logic [7:0] A_FDIV0 = 8'h14;
	localparam logic [7:0] A_FDIV1 = 8'h15;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_ERR_MASK = 8'h19;
	localparam logic [7:0] A_CONTROL = 8'h1a;
	localparam logic [7:0] A_SEQ = 8'h1b;
	localparam logic [7:0] A_DRIVE0 = 8'h1e;
	localparam logic [7:0] A_DRIVE1 = 8'h1f;
	// device_control fields
	localparam int B_ACTIVE_HI = 15;
	localparam int B_ACTIVE_LO = 14;
	localparam int B_SLEEP = 13;
	localparam int B_RES_OVR = 12;
	localparam int B_ACT_SEL = 11;
	localparam int B_AMP_OFF = 10;
	localparam int B_REF_SRC = 9;
	localparam int B_INT_DIS = 7;
	// channel_sequence_control fields
	localparam int B_SCAN = 15;
	localparam int B_RR_HI = 14;
	localparam int B_RR_LO = 13;
	localparam int B_DG_HI = 2;
	localparam int B_DG_LO = 0;
	// frequency divider fields and the status data ready bit
	localparam int B_FIN_HI = 15;
	localparam int B_FIN_LO = 12;
	localparam int B_FREF_HI = 9;
	localparam int B_FREF_LO = 0;
	localparam int B_DRDY = 0;
	// drive current register: level field
	localparam int B_IDRV_HI = 15;
	localparam int B_IDRV_LO = 11;
	localparam logic [15:0] RST_CONTROL = 16'h2801;
	localparam logic [15:0] RST_SEQ = 16'h020f;
	localparam logic [15:0] RST_ERR = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0080;
	localparam logic [15:0] RST_FDIV = 16'h0000;
	localparam logic [2:0] DEGLITCH_3M3 = 3'h4;
	localparam int TICKS_PER_UNIT = 16;
	// 1 us switch delay at 10 MHz
	localparam int SWITCH_NS = 1000;
	localparam int CLK_NS = 100;
	localparam int SWITCH_CYC = SWITCH_NS / CLK_NS;
	typedef enum logic [1:0] {INDCV_SLEEP, INDCV_SETTLE, INDCV_CONVERT, INDCV_SWITCH} indcv_state_t;
	typedef enum logic [2:0] {INDCV_H_IDLE, INDCV_H_REQ, INDCV_H_WAIT, INDCV_H_DONE} indcv_hstate_t;
endpackage : indcv_pkg

// *** test/indcv_link_sva.sv ***
// protocol checker for the register link between host and converter
`timescale 1ns/1ns
module indcv_link_sva
	import indcv_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset, high
	input wire logic req, // link request
	input wire logic we, // link write
	input wire logic [7:0] addr, // register index
	input wire logic [15:0] wdata, // write data
	input wire logic ack, // link answer
	input wire logic [15:0] rdata, // read data
	input wire logic int_n // interrupt, low
);
	logic mask_set;
	// set at request time, so it errs towards silence
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mask_set <= 1'b0;
		else if (req && we && addr == A_ERR_MASK && wdata != 16'h0000)
			mask_set <= 1'b1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (req && !ack |=> ack)
		else $error("no answer after request");
	a_ack_single: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	a_ack_cause: assert property (ack |-> $past(req))
		else $error("answer without request");
	a_req_drop: assert property (ack |=> !req)
		else $error("request kept after answer");
	a_req_steady: assert property (req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed while waiting");
	a_reset_quiet: assert property ($fell(rst_i) |-> !ack && rdata == 16'h0000 && int_n)
		else $error("link not quiet after reset");
	a_mask_quiet: assert property (!mask_set |-> int_n)
		else $error("interrupt with default mask");
	a_idle_gap: assert property ($fell(ack) |-> !req ##1 !ack)
		else $error("no idle cycle after answer");
	c_write: cover property (req && we && ack);
	c_read: cover property (req && !we && ack);
	c_wake: cover property (req && we && addr == A_CONTROL && !wdata[B_SLEEP]);
endmodule : indcv_link_sva

// *** test/testbench.sv ***
// self-checking bench joining host and converter ends over the link
`timescale 1ns/1ns
module testbench;
	import indcv_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, tick, ack, irq, conv, setl, rext, acal, fdrv, amp;
	logic [31:0] adr, wdat, rdat;
	logic [3:0] sel;
	logic [27:0] sample;
	logic [1:0] chan;
	logic [2:0] dg;
	logic [4:0] drv;
	logic [15:0] q;
	logic [15:0] mdl [0:31];
	int fails, n_tests, seed, sc, cc, gc, slen, clen, gap, seen, k;
	logic [7:0] rl [7] = '{A_CONTROL, A_SEQ, A_REF_COUNT0, A_REF_COUNT1, A_FDIV0, A_FDIV1, A_ERR_MASK};
	logic [7:0] pa [10] = '{A_REF_COUNT0, A_REF_COUNT1, A_SETTLE0, A_SETTLE1, A_FDIV0, A_FDIV1,
		A_ERR_MASK, A_SEQ, A_DRIVE0, A_DRIVE1};
	logic [15:0] pv [10] = '{16'h0010, 16'h0010, 16'h0002, 16'h0002, 16'h1001, 16'h1001,
		16'h0000, 16'h020c, 16'h9000, 16'h9000};
	indcv_link_if link();
	indcv_device indcv_device_inst(.clk_i, .rst_i, .link(link.dev), .ref_tick_int_i(1'b0),
		.ref_tick_ext_i(tick), .sample_i(sample), .chan_o(chan), .converting_o(conv),
		.settling_o(setl), .ref_ext_o(rext), .auto_cal_o(acal), .full_init_drive_o(fdrv),
		.amp_corr_o(amp), .deglitch_o(dg), .drive_level_o(drv));
	indcv_host indcv_host_inst(.clk_i, .rst_i, .link(link.host), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq));
	indcv_link_sva indcv_link_sva_inst(.clk_i, .rst_i, .req(link.req), .we(link.we),
		.addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
		.int_n(link.int_n));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// one reference tick every two clocks
	always @(posedge clk_i) begin
		tick <= ~tick;
		sc <= setl ? sc + 1 : 0;
		cc <= conv ? cc + 1 : 0;
		gc <= (setl || conv) ? 0 : gc + 1;
		if (!setl && sc > 0) slen <= sc;
		if (!conv && cc > 0) clen <= cc;
		if (setl && gc > 0) gap <= gc;
		if (conv) seen <= seen | (1 << chan);
	end
	task print_verdict;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] i, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= {22'h0, i, 2'b00};
		wdat <= {16'h0, d};
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[15:0];
		if (w && (i == A_CONTROL || mdl[A_CONTROL][B_SLEEP])) mdl[i[4:0]] = d;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rchk(input logic [7:0] i);
		wb(1'b0, i, 16'h0000);
		chk("register", mdl[i[4:0]], q);
	endtask : rchk
	task wt(input logic v);
		k = 0;
		while (((setl || conv) !== v) && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		chk("activity", v, setl || conv);
	endtask : wt
	initial begin
		#(100 * 20000);
		fails++;
		print_verdict;
	end
	initial begin
		seed = 32'h637937ec;
		{cyc, stb, we, sel, tick, adr, wdat, fails, n_tests, seen} = '0;
		rst_i = 1'b1;
		sample = $random(seed);
		foreach (mdl[j]) mdl[j] = 16'h0000;
		mdl[A_CONTROL] = RST_CONTROL;
		mdl[A_SEQ] = RST_SEQ;
		mdl[A_REF_COUNT0] = RST_COUNT;
		mdl[A_REF_COUNT1] = RST_COUNT;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("asleep", 1'b0, conv || setl);
		foreach (rl[j]) rchk(rl[j]);
		for (int j = 0; j < 4; j++) begin
			wb(1'b1, pa[j], 16'($random(seed)));
			rchk(pa[j]);
		end
		foreach (pa[j]) begin
			wb(1'b1, pa[j], pv[j]);
			rchk(pa[j]);
		end
		wb(1'b1, A_CONTROL, 16'h1601);
		chk("ref source", 1'b1, rext);
		chk("auto cal", 1'b0, acal);
		chk("full drive", 1'b1, fdrv);
		chk("amp corr", 1'b0, amp);
		chk("deglitch", DEGLITCH_3M3, dg);
		chk("drive level", 5'd18, drv);
		wt(1'b1);
		repeat (3 * (64 + 512)) @(posedge clk_i);
		chk("settle len", 1'b1, slen >= 62 && slen <= 66);
		chk("conv len", 1'b1, clen >= 510 && clen <= 514);
		chk("single chan", 1, seen);
		wb(1'b1, A_REF_COUNT0, 16'h0123);
		rchk(A_REF_COUNT0);
		wb(1'b0, A_DATA0_MSB, 16'h0000);
		chk("result msb", sample[27:16], q[11:0]);
		wb(1'b0, A_DATA0_LSB, 16'h0000);
		chk("result lsb", sample[15:0], q);
		wb(1'b0, 8'h30, 16'h0000);
		chk("unmapped", 16'h0000, q);
		wb(1'b1, A_CONTROL, 16'h3601);
		wt(1'b0);
		wb(1'b1, A_SEQ, 16'h820c);
		seen <= 0;
		wb(1'b1, A_CONTROL, 16'h1601);
		wt(1'b1);
		repeat (4 * (64 + 512 + SWITCH_CYC)) @(posedge clk_i);
		chk("scan chans", 3, seen);
		chk("switch gap", 1'b1, gap >= SWITCH_CYC - 2 && gap <= SWITCH_CYC + 2);
		chk("irq quiet", 1'b0, irq);
		wb(1'b0, A_DATA1_MSB, 16'h0000);
		chk("result1 msb", sample[27:16], q[11:0]);
		wb(1'b0, A_DATA1_LSB, 16'h0000);
		chk("result1 lsb", sample[15:0], q);
		// unmask ready while asleep, then wake and expect an interrupt
		wb(1'b1, A_CONTROL, 16'h3601);
		wb(1'b1, A_ERR_MASK, 16'h0001);
		rchk(A_ERR_MASK);
		wb(1'b1, A_CONTROL, 16'h1601);
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(posedge clk_i);
			k++;
		end
		chk("irq raised", 1'b1, irq);
		wb(1'b0, A_STATUS, 16'h0000);
		chk("status ready", 1'b1, q[B_DRDY]);
		repeat (2) @(posedge clk_i);
		chk("irq released", 1'b0, irq);
		print_verdict;
	end
endmodule : testbench
